// *** rtl/windowed_timeout_guard_params.svh ***
// Offsets, field positions, keys and reset values of the windowed watchdog
`ifndef GUARD_PARAMS_SVH
`define GUARD_PARAMS_SVH
`define WD_OFS_CTRL   8'h00
`define WD_OFS_TMO    8'h04
`define WD_OFS_FEED   8'h08
`define WD_OFS_WIN    8'h0c
`define WD_OFS_WARN   8'h10
`define WD_OFS_CNT    8'h14
`define WD_OFS_STS    8'h18
`define WD_OFS_MASK   8'h1c
`define WD_CTL_EN     0
`define WD_CTL_FIM    1
`define WD_CTL_WEN    2
`define WD_CTL_WREN   3
`define WD_ST_TMO     0
`define WD_ST_WARN    1
`define WD_ST_FAULT   2
`define WD_ST_RSTF    3
`define WD_KEY_ARM    8'haa
`define WD_KEY_GO     8'h55
`define WD_TMO_MIN    24'h00_00ff
`define WD_TMO_RST    24'hff_ffff
`define WD_WIN_RST    24'hff_ffff
`define WD_WARN_RST   24'h00_0000
`define WD_PRE_LAST   2'h3
`define WD_ST_W       4
`define WD_RESP_OKAY  2'h0
`define WD_RESP_SLV   2'h2
`define WD_ZERO32     32'h0000_0000
`endif

// *** rtl/windowed_timeout_guard_pkg.sv ***
// Types of the windowed watchdog
package guard_pkg;
    typedef enum logic [0:0] {
        FEED_IDLE  = 1'b0,
        FEED_ARMED = 1'b1
    } feed_t;
    typedef struct packed {
        logic        awv;
        logic [7:0]  awa;
        logic        wv;
        logic [31:0] wd;
        logic        bv;
        logic [1:0]  br;
        logic        rv;
        logic [31:0] rd;
        logic [1:0]  rr;
        logic        s1;
        logic        s2;
        logic        s3;
        logic [1:0]  pre;
        logic [23:0] cnt;
        logic [23:0] tmo;
        logic [23:0] win;
        logic [23:0] wrn;
        logic        en;
        logic        fim;
        logic        wen;
        logic        wren;
        feed_t       fst;
        logic [3:0]  sts;
        logic [3:0]  msk;
        logic        crst;
    } state_t;
endpackage : guard_pkg

// *** rtl/windowed_timeout_guard.sv ***
// Windowed watchdog with AXI4-Lite registers
`timescale 1ns/1ns
`default_nettype none
`include "windowed_timeout_guard_params.svh"
module windowed_timeout_guard (
    input  wire logic        aclk,          // Bus clock, 20 MHz
    input  wire logic        aresetn,       // Synchronous reset
    input  wire logic        low_power_osc, // Tick source, asynchronous
    input  wire logic [7:0]  s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Byte strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [7:0]  s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    output logic             chip_reset,    // One-cycle chip reset request
    output logic             irq            // Level interrupt
);
    guard_pkg::state_t q, d;

    function automatic logic hit(input logic [7:0] a);
        hit = (a[1:0] == 2'h0) && (a <= `WD_OFS_MASK);
    endfunction : hit

    function automatic logic [31:0] ext24(input logic [23:0] v);
        ext24 = {8'h00, v};
    endfunction : ext24

    logic        wr_go;
    logic        tick;
    logic        pstb;
    logic        feed_wr;
    logic        key_arm;
    logic        key_go;
    logic        feed_try;
    logic        win_bad;
    logic        feed_ok;
    logic        fault_ev;
    logic        tmo_ev;
    logic        warn_ev;
    logic        wd_ev;
    logic [3:0]  st_set;
    logic [3:0]  st_clr;
    logic [31:0] rdat;

    always_comb begin
        wr_go    = q.awv && q.wv && !q.bv;
        tick     = q.s2 && !q.s3;
        pstb     = q.en && tick && (q.pre == `WD_PRE_LAST);
        feed_wr  = wr_go && (q.awa == `WD_OFS_FEED);
        key_arm  = feed_wr && (q.wd[7:0] == `WD_KEY_ARM);
        key_go   = feed_wr && (q.wd[7:0] == `WD_KEY_GO);
        feed_try = (q.fst == guard_pkg::FEED_ARMED) && key_go;
        win_bad  = q.wen && (q.cnt > q.win);
        feed_ok  = feed_try && !(q.en && win_bad);
        fault_ev = 1'b0;
        if (q.en && wr_go) begin
            unique case (q.fst)
                guard_pkg::FEED_IDLE:
                    fault_ev = feed_wr && !key_arm;
                guard_pkg::FEED_ARMED:
                    fault_ev = !key_go || win_bad;
            endcase
        end
        tmo_ev  = pstb && (q.cnt == 24'h00_0000);
        warn_ev = q.wren && pstb && (q.cnt == q.wrn);
        wd_ev   = fault_ev || tmo_ev;
        st_set  = '0;
        st_set[`WD_ST_TMO]   = tmo_ev;
        st_set[`WD_ST_WARN]  = warn_ev;
        st_set[`WD_ST_FAULT] = fault_ev;
        st_set[`WD_ST_RSTF]  = wd_ev && !q.fim;
        st_clr = '0;
        if (wr_go && (q.awa == `WD_OFS_STS)) begin
            st_clr = q.wd[`WD_ST_W-1:0];
        end
        rdat = `WD_ZERO32;
        unique case (s_axi_araddr)
            `WD_OFS_CTRL: begin
                rdat[`WD_CTL_EN]   = q.en;
                rdat[`WD_CTL_FIM]  = q.fim;
                rdat[`WD_CTL_WEN]  = q.wen;
                rdat[`WD_CTL_WREN] = q.wren;
            end
            `WD_OFS_TMO:  rdat = ext24(q.tmo);
            `WD_OFS_WIN:  rdat = ext24(q.win);
            `WD_OFS_WARN: rdat = ext24(q.wrn);
            `WD_OFS_CNT:  rdat = ext24(q.cnt);
            `WD_OFS_STS:  rdat = {28'h000_0000, q.sts};
            `WD_OFS_MASK: rdat = {28'h000_0000, q.msk};
            default:      rdat = `WD_ZERO32;
        endcase
    end

    always_comb begin
        d = q;
        d.s1   = low_power_osc;
        d.s2   = q.s1;
        d.s3   = q.s2;
        d.crst = wd_ev && !q.fim;
        if (q.en && tick) begin
            d.pre = q.pre + 2'h1;
        end
        // Bus write channels
        if (s_axi_awvalid && !q.awv) begin
            d.awv = 1'b1;
            d.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.wv) begin
            d.wv = 1'b1;
            d.wd = s_axi_wdata;
        end
        if (q.bv && s_axi_bready) begin
            d.bv = 1'b0;
        end
        if (wr_go) begin
            d.awv = 1'b0;
            d.wv  = 1'b0;
            d.bv  = 1'b1;
            d.br  = hit(q.awa) ? `WD_RESP_OKAY : `WD_RESP_SLV;
            unique case (q.awa)
                `WD_OFS_CTRL: begin
                    d.en = q.en | q.wd[`WD_CTL_EN];
                    if (!q.en) begin
                        d.fim  = q.wd[`WD_CTL_FIM];
                        d.wen  = q.wd[`WD_CTL_WEN];
                        d.wren = q.wd[`WD_CTL_WREN];
                    end
                end
                `WD_OFS_TMO: begin
                    if (q.wd[23:0] < `WD_TMO_MIN) begin
                        d.tmo = `WD_TMO_MIN;
                    end else begin
                        d.tmo = q.wd[23:0];
                    end
                end
                `WD_OFS_WIN:  d.win = q.wd[23:0];
                `WD_OFS_WARN: d.wrn = q.wd[23:0];
                `WD_OFS_MASK: d.msk = q.wd[`WD_ST_W-1:0];
                default:      d.en  = q.en;
            endcase
            if (key_arm && (q.fst == guard_pkg::FEED_IDLE)) begin
                d.fst = guard_pkg::FEED_ARMED;
            end else begin
                d.fst = guard_pkg::FEED_IDLE;
            end
        end
        // Bus read channel
        if (q.rv && s_axi_rready) begin
            d.rv = 1'b0;
        end
        if (s_axi_arvalid && !q.rv) begin
            d.rv = 1'b1;
            d.rd = rdat;
            d.rr = hit(s_axi_araddr) ? `WD_RESP_OKAY : `WD_RESP_SLV;
        end
        // Counter
        if (!q.en || feed_ok) begin
            d.cnt = q.tmo;
            if (feed_ok) begin
                d.pre = 2'h0;
            end
        end else if (pstb) begin
            d.cnt = q.cnt - 24'h00_0001;
        end
        if (wd_ev) begin
            d.en  = 1'b0;
            d.cnt = q.tmo;
            d.pre = 2'h0;
            d.fst = guard_pkg::FEED_IDLE;
        end
        d.sts = (q.sts & ~st_clr) | st_set;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q      <= '0;
            q.tmo  <= `WD_TMO_RST;
            q.win  <= `WD_WIN_RST;
            q.wrn  <= `WD_WARN_RST;
            q.cnt  <= `WD_TMO_RST;
            q.fst  <= guard_pkg::FEED_IDLE;
        end else begin
            q <= d;
        end
    end

    assign s_axi_awready = !q.awv;
    assign s_axi_wready  = !q.wv;
    assign s_axi_bvalid  = q.bv;
    assign s_axi_bresp   = q.br;
    assign s_axi_arready = !q.rv;
    assign s_axi_rvalid  = q.rv;
    assign s_axi_rdata   = q.rd;
    assign s_axi_rresp   = q.rr;
    assign chip_reset    = q.crst;
    assign irq           = |(q.sts & q.msk);

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_TMO_RESET: assert property (tmo_ev && !q.fim |=> chip_reset && !q.en)
        else $error("expiry gave no chip reset");
    AST_WINDOW: assert property (feed_try && q.en && win_bad |=> q.sts[`WD_ST_FAULT])
        else $error("early feed not flagged");
    // A feed or event in the same cycle reloads the counter instead of stepping it
    AST_WARN: assert property (warn_ev && !feed_ok && !wd_ev |=>
        q.sts[`WD_ST_WARN] ##0 q.cnt == $past(q.wrn) - 24'h00_0001)
        else $error("warning flag missing");
    AST_EN_STICKY: assert property (q.en && !wd_ev |=> q.en)
        else $error("enable dropped without event");
    AST_FAULT: assert property (fault_ev |=> (q.fim ? !chip_reset : chip_reset))
        else $error("fault action wrong");
    AST_RST_FLAG: assert property (chip_reset |-> q.sts[`WD_ST_RSTF])
        else $error("reset flag not set");
    AST_PRESCALE: assert property (q.en && !pstb && !feed_ok && !wd_ev |=> $stable(q.cnt))
        else $error("counter moved off prescale");
    AST_TICK: assert property (pstb |-> $past(q.s2) == 1'b0 && q.s2)
        else $error("step without oscillator edge");
    AST_RELOAD: assert property (feed_ok |=> q.cnt == $past(q.tmo) && q.pre == 2'h0)
        else $error("feed did not reload");
endmodule : windowed_timeout_guard
`default_nettype wire

// *** test/windowed_timeout_guard_bench.sv ***
// Self-checking bench of the windowed watchdog
`timescale 1ns/1ns
`default_nettype none
`include "windowed_timeout_guard_params.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_fail++; \
$display("Error %s expected %h seen %h", nm, e, g); end end
module windowed_timeout_guard_bench;
    logic        aclk = 1'h0, low_power_osc = 1'h0, chip_reset, irq, hit;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        aresetn = 1'h0, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0;
    logic        s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, rd;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
    int          n_fail = 0, checks_done = 0, n;

    windowed_timeout_guard dut (.aclk, .aresetn, .low_power_osc, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .chip_reset, .irq);

    initial forever #25 aclk = ~aclk;
    // Tick source of 1 MHz, phase unrelated to the bus clock
    initial #7 forever #500 low_power_osc = ~low_power_osc;

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        @(posedge aclk);
    endtask : wr

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge aclk);
        `CHK($sformatf("reg %h", a), e, rd)
    endtask : rc

    // Waits for a reset request or interrupt, cycles counted in n
    task automatic wt(input int lim);
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (!(chip_reset || irq) && n < lim);
        hit = chip_reset;
    endtask : wt

    task automatic t_reset;
        rc(`WD_OFS_CTRL, 32'h0000_0000);
        rc(`WD_OFS_TMO, 32'h00ff_ffff);
        rc(`WD_OFS_WIN, 32'h00ff_ffff);
        rc(`WD_OFS_WARN, 32'h0000_0000);
        rc(`WD_OFS_CNT, 32'h00ff_ffff);
        rc(`WD_OFS_STS, 32'h0000_0000);
        rc(8'h20, 32'h0000_0000);
        `CHK("rresp", `WD_RESP_SLV, rsp)
        wr(8'h06, 32'h0000_0001);
        `CHK("bresp", `WD_RESP_SLV, rsp)
        rc(`WD_OFS_CTRL, 32'h0000_0000);
        wr(`WD_OFS_TMO, 32'h0000_0010);
        rc(`WD_OFS_TMO, 32'h0000_00ff);
        $display("Done reset values");
    endtask : t_reset

    task automatic t_fault;
        wr(`WD_OFS_MASK, 32'h0000_000f);
        wr(`WD_OFS_CTRL, 32'h0000_0003);
        wr(`WD_OFS_CTRL, 32'h0000_0000);
        rc(`WD_OFS_CTRL, 32'h0000_0003);
        `CHK("irq", 1'h0, irq)
        wr(`WD_OFS_FEED, 32'h0000_0055);
        `CHK("irq", 1'h1, irq)
        rc(`WD_OFS_STS, 32'h0000_0004);
        rc(`WD_OFS_CTRL, 32'h0000_0002);
        wr(`WD_OFS_STS, 32'h0000_0004);
        `CHK("irq", 1'h0, irq)
        $display("Done feed fault");
    endtask : t_fault

    task automatic t_timeout;
        wr(`WD_OFS_MASK, 32'h0000_0000);
        wr(`WD_OFS_CTRL, 32'h0000_0001);
        repeat (3000) @(posedge aclk);
        wr(`WD_OFS_FEED, {24'h00_0000, `WD_KEY_ARM});
        wr(`WD_OFS_FEED, {24'h00_0000, `WD_KEY_GO});
        rc(`WD_OFS_CNT, 32'h0000_00ff);
        wt(25000);
        `CHK("chip reset", 1'h1, hit)
        `CHK("reset delay", 1'h1, n >= 20440 && n <= 20530)
        rc(`WD_OFS_STS, 32'h0000_0009);
        rc(`WD_OFS_CTRL, 32'h0000_0000);
        wr(`WD_OFS_STS, 32'h0000_000f);
        $display("Done time-out");
    endtask : t_timeout

    task automatic t_warn;
        wr(`WD_OFS_WARN, 32'h0000_0080);
        wr(`WD_OFS_WIN, 32'h0000_0010);
        wr(`WD_OFS_MASK, 32'h0000_0002);
        wr(`WD_OFS_CTRL, 32'h0000_000f);
        wt(12000);
        // 128 steps of 4 ticks of 20 bus cycles, plus tick phase
        `CHK("warn delay", 1'h1, n >= 10200 && n <= 10270)
        rc(`WD_OFS_STS, 32'h0000_0002);
        wr(`WD_OFS_FEED, {24'h00_0000, `WD_KEY_ARM});
        wr(`WD_OFS_FEED, {24'h00_0000, `WD_KEY_GO});
        rc(`WD_OFS_STS, 32'h0000_0006);
        rc(`WD_OFS_CTRL, 32'h0000_000e);
        $display("Done warning and window");
    endtask : t_warn

    // Feed inside the window is taken; a write between the keys resets the chip
    task automatic t_feed_rules;
        wr(`WD_OFS_STS, 32'h0000_000f);
        wr(`WD_OFS_MASK, 32'h0000_0000);
        wr(`WD_OFS_WIN, 32'h00ff_ffff);
        wr(`WD_OFS_CTRL, 32'h0000_0005);
        wr(`WD_OFS_FEED, {24'h00_0000, `WD_KEY_ARM});
        wr(`WD_OFS_FEED, {24'h00_0000, `WD_KEY_GO});
        rc(`WD_OFS_STS, 32'h0000_0000);
        rc(`WD_OFS_CTRL, 32'h0000_0005);
        wr(`WD_OFS_FEED, {24'h00_0000, `WD_KEY_ARM});
        wr(`WD_OFS_WIN, 32'h00ff_ffff);
        rc(`WD_OFS_STS, 32'h0000_000c);
        rc(`WD_OFS_CTRL, 32'h0000_0004);
        $display("Done feed sequence rules");
    endtask : t_feed_rules

    task automatic print_verdict;
        $display("Checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset();
        t_fault();
        t_timeout();
        t_warn();
        t_feed_rules();
        print_verdict();
    end

    initial begin
        repeat (60000) @(posedge aclk);
        n_fail++;
        print_verdict();
    end
endmodule : windowed_timeout_guard_bench
`undef CHK
`default_nettype wire
